// ==== common/axsf_consts.svh ====
// Register map, field positions and reset values of the stream queue
`ifndef AXSF_CONSTS_SVH
`define AXSF_CONSTS_SVH

// Register byte offsets
`define AXSF_CTRL_OFS 8'h00
`define AXSF_STAT_OFS 8'h04
`define AXSF_DEPTH_OFS 8'h08

// Field positions
`define AXSF_CTRL_FLUSH_BIT 0
`define AXSF_STAT_EMPTY_BIT 30
`define AXSF_STAT_FULL_BIT 31

// Reset values
`define AXSF_PRDATA_RST 32'h0000_0000
`define AXSF_COUNT_RST 0

// Documented depth range in words
`define AXSF_DEPTH_MIN 16
`define AXSF_DEPTH_MAX 4194304

`endif

// ==== common/axsf_pkg.sv ====
// Types shared by the stream queue modules
package axsf_pkg;

    // Storage flavour: registered-read block memory or combinational-read distributed memory
    typedef enum logic [0:0]
    {
        AXSF_RAM_BLOCK = 1'b0,
        AXSF_RAM_DIST = 1'b1
    } axsf_ram_style_type;

endpackage : axsf_pkg

// ==== common/axsf_ram_if.sv ====
// Storage port bundle between queue control and its memory
`timescale 1ns/1ns
interface axsf_ram_if #(
    parameter int AW = 4,
    parameter int W = 8
);
    logic we;
    logic [AW-1:0] wa;
    logic [W-1:0] wd;
    logic [AW-1:0] ra;
    logic [W-1:0] rd;

    modport ctrl (output we, output wa, output wd, output ra, input rd);
    modport mem (input we, input wa, input wd, input ra, output rd);
endinterface : axsf_ram_if

// ==== rtl/axsf_ram.sv ====
// Word storage of the stream queue, block or distributed flavour
`timescale 1ns/1ns
module axsf_ram #(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int W = 8,
    parameter axsf_pkg::axsf_ram_style_type RAM_STYLE = axsf_pkg::AXSF_RAM_BLOCK
)(
    // Clock
    input wire logic pclk,
    // Storage port
    axsf_ram_if.mem ram
);
    import axsf_pkg::*;

    logic [W-1:0] mem_q [DEPTH];

    // Write port, no reset so it maps onto memory primitives
    always_ff @(posedge pclk)
    begin
        if (ram.we)
        begin
            mem_q[ram.wa] <= ram.wd;
        end
    end

    generate
        if (RAM_STYLE == AXSF_RAM_BLOCK)
        begin : g_block
            logic [W-1:0] rd_q;
            // Registered read; a write to the address being read is forwarded so the head is never stale
            always_ff @(posedge pclk)
            begin
                rd_q <= (ram.we && ram.wa == ram.ra) ? ram.wd : mem_q[ram.ra];
            end
            assign ram.rd = rd_q;
        end
        else
        begin : g_dist
            // Combinational read of the current head
            assign ram.rd = mem_q[ram.ra];
        end
    endgenerate

endmodule : axsf_ram

// ==== rtl/axsf_apb.sv ====
// APB register slave of the stream queue: flush control and status
`timescale 1ns/1ns
`include "axsf_consts.svh"
module axsf_apb #(
    parameter int CW = 5,
    parameter int DEPTH = 16
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Queue state and control
    input wire logic [CW-1:0] count,
    input wire logic full,
    input wire logic empty,
    output logic flush
);
    import axsf_pkg::*;

    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic flush_q;
    logic [31:0] rd_w;
    logic miss_w;
    wire setup_w = psel && !penable;
    wire access_w = psel && penable && pready_q;

    // Address decode of the read value and of unmapped offsets
    always_comb
    begin
        rd_w = `AXSF_PRDATA_RST;
        miss_w = 1'b0;
        if (paddr == `AXSF_CTRL_OFS)
        begin
            rd_w = `AXSF_PRDATA_RST;
        end
        else if (paddr == `AXSF_STAT_OFS)
        begin
            rd_w[CW-1:0] = count;
            rd_w[`AXSF_STAT_FULL_BIT] = full;
            rd_w[`AXSF_STAT_EMPTY_BIT] = empty;
        end
        else if (paddr == `AXSF_DEPTH_OFS)
        begin
            rd_w = 32'(DEPTH);
        end
        else
        begin
            miss_w = 1'b1;
        end
    end

    // Answer is prepared in the setup cycle so every access takes one wait-free access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= `AXSF_PRDATA_RST;
            pslverr_q <= 1'b0;
            flush_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup_w;
            prdata_q <= setup_w ? rd_w : prdata_q;
            pslverr_q <= setup_w && miss_w;
            flush_q <= access_w && pwrite && paddr == `AXSF_CTRL_OFS && pwdata[`AXSF_CTRL_FLUSH_BIT];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign flush = flush_q;

    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("APB access did not complete in one access cycle");

endmodule : axsf_apb

// ==== rtl/axsf_fifo.sv ====
// Single-clock stream queue with stream write and read channels and APB status
// What this block does
// - Words leave in the order they arrived
// - Transfer only when valid and ready coincide
// - Write ready only when a word fits
// - Depth is a parameter, sixteen to 4M
// - Whole-byte payload passes through unchanged
// - Strobe, one bit per byte, stored with word
// - Keep bits stored and forwarded per word
// - Packet end marker travels with its word
// - Destination, identifier, user fields travel along
// - Optional active-low reset empties the queue
// - Occupancy count lags stored words by one edge
// - Accepted write shows in count next edge
// - Count width is log2 depth plus one
// - One clock; block or distributed storage option
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "axsf_consts.svh"
module axsf_fifo #(
    parameter int DEPTH = 16,
    parameter int DATA_BYTES = 4,
    parameter int DEST_W = 4,
    parameter int ID_W = 4,
    parameter int USER_W = 4,
    parameter bit HAS_STRB = 1'b1,
    parameter bit HAS_KEEP = 1'b1,
    parameter bit HAS_LAST = 1'b1,
    parameter bit HAS_DEST = 1'b1,
    parameter bit HAS_ID = 1'b1,
    parameter bit HAS_USER = 1'b1,
    parameter bit HAS_ARESTN = 1'b1,
    parameter bit HAS_COUNT = 1'b1,
    parameter axsf_pkg::axsf_ram_style_type RAM_STYLE = axsf_pkg::AXSF_RAM_BLOCK
)(
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic arestn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Write channel, stream slave
    input wire logic s_axis_tvalid,
    output logic s_axis_tready,
    input wire logic [8*DATA_BYTES-1:0] s_axis_tdata,
    input wire logic [DATA_BYTES-1:0] s_axis_tstrb,
    input wire logic [DATA_BYTES-1:0] s_axis_tkeep,
    input wire logic s_axis_tlast,
    input wire logic [DEST_W-1:0] s_axis_tdest,
    input wire logic [ID_W-1:0] s_axis_tid,
    input wire logic [USER_W-1:0] s_axis_tuser,
    // Read channel, stream master
    output logic m_axis_tvalid,
    input wire logic m_axis_tready,
    output logic [8*DATA_BYTES-1:0] m_axis_tdata,
    output logic [DATA_BYTES-1:0] m_axis_tstrb,
    output logic [DATA_BYTES-1:0] m_axis_tkeep,
    output logic m_axis_tlast,
    output logic [DEST_W-1:0] m_axis_tdest,
    output logic [ID_W-1:0] m_axis_tid,
    output logic [USER_W-1:0] m_axis_tuser,
    // Occupancy
    output logic [$clog2(DEPTH):0] data_count
);
    import axsf_pkg::*;

    localparam int DW = 8 * DATA_BYTES;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int W = DW + 2 * DATA_BYTES + 1 + DEST_W + ID_W + USER_W;
    localparam int KP = DW + DATA_BYTES;
    localparam int LP = KP + DATA_BYTES;
    localparam int DP = LP + 1;
    localparam int IP = DP + DEST_W;
    localparam int UP = IP + ID_W;

    // Wrap-around pointer step, used by both pointers
    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_next

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] data_count_q;
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] rd_ptr_d;
    logic s_tready_q;
    logic m_tvalid_q;
    logic [W-1:0] m_word_q;
    logic [W-1:0] m_word_d;
    logic m_tvalid_d;
    logic reg_flush;
    logic [CW-1:0] mem_cnt;

    axsf_ram_if #(.AW(AW), .W(W)) ram_bus ();

    // Absent qualifiers read as all bytes valid, absent fields as zero
    wire [DATA_BYTES-1:0] strb_w = HAS_STRB ? s_axis_tstrb : '1;
    wire [DATA_BYTES-1:0] keep_w = HAS_KEEP ? s_axis_tkeep : '1;
    wire last_w = HAS_LAST ? s_axis_tlast : 1'b0;
    wire [DEST_W-1:0] dest_w = HAS_DEST ? s_axis_tdest : '0;
    wire [ID_W-1:0] id_w = HAS_ID ? s_axis_tid : '0;
    wire [USER_W-1:0] user_w = HAS_USER ? s_axis_tuser : '0;
    // Sideband is packed beside the payload so it cannot drift from its word
    wire [W-1:0] in_word = {user_w, id_w, dest_w, last_w, keep_w, strb_w, s_axis_tdata};

    // Handshakes and flush sources
    wire flush = (HAS_ARESTN && !arestn) || reg_flush;
    wire push = s_axis_tvalid && s_tready_q && !flush;
    wire pop = m_tvalid_q && m_axis_tready;

    // The output register counts as one stored word; the rest sit in memory
    assign mem_cnt = count_q - CW'(m_tvalid_q);
    wire mem_empty = (mem_cnt == '0);
    wire load = (!m_tvalid_q || pop) && (!mem_empty || push);
    wire bypass = load && mem_empty;
    wire from_mem = load && !mem_empty;

    // Next head, count and valid
    assign rd_ptr_d = from_mem ? ptr_next(rd_ptr_q) : rd_ptr_q;
    assign m_word_d = bypass ? in_word : (from_mem ? ram_bus.rd : m_word_q);
    assign m_tvalid_d = load || (m_tvalid_q && !pop);
    assign count_d = count_q + CW'(push) - CW'(pop);

    // Storage port; block memory is addressed one cycle ahead to hide its read register
    assign ram_bus.we = push && !bypass;
    assign ram_bus.wa = wr_ptr_q;
    assign ram_bus.wd = in_word;
    assign ram_bus.ra = (RAM_STYLE == AXSF_RAM_BLOCK) ? rd_ptr_d : rd_ptr_q;

    // Queue state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= CW'(`AXSF_COUNT_RST);
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            s_tready_q <= 1'b0;
            m_tvalid_q <= 1'b0;
        end
        else if (flush)
        begin
            count_q <= CW'(`AXSF_COUNT_RST);
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            s_tready_q <= 1'b0;
            m_tvalid_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            wr_ptr_q <= ram_bus.we ? ptr_next(wr_ptr_q) : wr_ptr_q;
            rd_ptr_q <= rd_ptr_d;
            s_tready_q <= (count_d < CW'(DEPTH));
            m_tvalid_q <= m_tvalid_d;
        end
    end

    // Output word and reported count; the count lags one edge, so it under-reports after a push and over-reports after a pop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m_word_q <= '0;
            data_count_q <= CW'(`AXSF_COUNT_RST);
        end
        else
        begin
            m_word_q <= m_word_d;
            data_count_q <= HAS_COUNT ? count_q : '0;
        end
    end

    axsf_ram #(
        .DEPTH(DEPTH),
        .AW(AW),
        .W(W),
        .RAM_STYLE(RAM_STYLE)
    ) u_ram (
        .pclk(pclk),
        .ram(ram_bus.mem)
    );

    axsf_apb #(
        .CW(CW),
        .DEPTH(DEPTH)
    ) u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .count(count_q),
        .full(count_q == CW'(DEPTH)),
        .empty(count_q == '0),
        .flush(reg_flush)
    );

    // Port mapping of the packed output word
    assign s_axis_tready = s_tready_q;
    assign m_axis_tvalid = m_tvalid_q;
    assign m_axis_tdata = m_word_q[DW-1:0];
    assign m_axis_tstrb = m_word_q[KP-1:DW];
    assign m_axis_tkeep = m_word_q[LP-1:KP];
    assign m_axis_tlast = m_word_q[LP];
    assign m_axis_tdest = m_word_q[IP-1:DP];
    assign m_axis_tid = m_word_q[UP-1:IP];
    assign m_axis_tuser = m_word_q[W-1:UP];
    assign data_count = data_count_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    depth_range_a: assert property (DEPTH >= `AXSF_DEPTH_MIN && DEPTH <= `AXSF_DEPTH_MAX)
        else $error("Queue depth outside the supported range");

    no_overflow_a: assert property (s_axis_tready |-> count_q < CW'(DEPTH))
        else $error("Write ready raised while the queue is full");

    full_stall_a: assert property (count_q == CW'(DEPTH) && !pop |=> !s_axis_tready)
        else $error("Write ready stayed high with a full queue");

    empty_idle_a: assert property (count_q == '0 |-> !m_axis_tvalid)
        else $error("Read valid raised while the queue is empty");

    out_hold_a: assert property (m_axis_tvalid && !m_axis_tready && !flush |=> m_axis_tvalid && $stable(m_word_q))
        else $error("Read word changed before its handshake");

    pass_through_a: assert property (push && count_q == '0 |=> m_axis_tvalid && m_word_q == $past(in_word))
        else $error("Word into an empty queue did not appear unchanged");

    count_step_a: assert property (!flush |=> count_q == $past(count_q) + CW'($past(push)) - CW'($past(pop)))
        else $error("Occupancy does not follow accepted writes and reads");

    count_lag_a: assert property (HAS_COUNT && push && !pop && !flush |=> ##1 data_count == $past(count_q, 2) + 1'b1)
        else $error("Accepted write not in the reported count one edge later");

    flush_empty_a: assert property (flush |=> count_q == '0 && !m_axis_tvalid && !s_axis_tready ##1 s_axis_tready)
        else $error("Flush did not empty the queue");

    block_fwd_a: assert property (RAM_STYLE == AXSF_RAM_BLOCK && ram_bus.we && ram_bus.wa == ram_bus.ra
        |=> ram_bus.rd == $past(ram_bus.wd))
        else $error("Block storage returned a stale word on a colliding read");

    // An accepted word is never lost: something is always on offer right after it
    valid_after_push_a: assert property (push |=> m_axis_tvalid)
        else $error("Accepted word did not leave the queue visible");

    // Occupancy can never pass the capacity
    count_bound_a: assert property (count_q <= CW'(DEPTH))
        else $error("Occupancy above capacity");

    // A stored word is always presented, so the head never hides behind the memory
    nonempty_valid_a: assert property (count_q != '0 |-> m_axis_tvalid)
        else $error("Read valid low although words are stored");

    // The last free slot taken closes the write side at that same edge
    ready_drop_a: assert property (count_q == CW'(DEPTH - 1) && push && !pop |=> !s_axis_tready)
        else $error("Write ready stayed high after the queue filled");

    // A pop with more words behind it refills the output at once
    pop_refill_a: assert property (pop && count_q > CW'(1) && !flush |=> m_axis_tvalid)
        else $error("Output not refilled after a pop");

    // With no traffic the occupancy stays put
    count_hold_a: assert property (!push && !pop && !flush |=> $stable(count_q))
        else $error("Occupancy moved without a transfer");

    // The reported count fits its width and never exceeds capacity
    dcount_ceiling_a: assert property (data_count <= CW'(DEPTH))
        else $error("Reported count above capacity");

    // Both pointers stay inside the configured depth, also when it is not a power of two
    ptr_range_a: assert property (32'(wr_ptr_q) < DEPTH && 32'(rd_ptr_q) < DEPTH)
        else $error("Storage pointer outside the configured depth");

endmodule : axsf_fifo

// ==== test/axsf_sink_model.sv ====
// Downstream stream sink model with a selectable readiness pattern
`timescale 1ns/1ns
module axsf_sink_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stream from the queue
    input wire logic m_axis_tvalid,
    input wire logic [52:0] m_word,
    output logic m_axis_tready,
    // Pattern: 0 stall, 1 always ready, 2 every other cycle
    input wire logic [1:0] mode,
    // Beat taken at the last edge
    output logic got,
    output logic [52:0] got_word
);
    logic tog_q;

    // Ready is registered, so a pattern change shows one cycle late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tog_q <= 1'b0;
            m_axis_tready <= 1'b0;
            got <= 1'b0;
            got_word <= 53'h0;
        end
        else
        begin
            tog_q <= ~tog_q;
            m_axis_tready <= (mode == 2'h1) || (mode == 2'h2 && tog_q);
            got <= m_axis_tvalid && m_axis_tready;
            got_word <= m_word;
        end
    end
endmodule : axsf_sink_model

// ==== test/axsf_fifo_tb.sv ====
// Self-checking bench of the stream queue: traffic, flush, reset and status registers
`timescale 1ns/1ns
`include "axsf_consts.svh"
module axsf_fifo_tb;
    localparam int DEPTH = 16;
    logic pclk, presetn, arestn, psel, penable, pwrite, pready, pslverr, err;
    logic s_valid, s_ready, m_valid, m_ready, got;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [52:0] s_word, got_word;
    wire logic [52:0] m_word;
    logic [1:0] mode;
    logic [4:0] data_count;
    logic [52:0] exp_q[$];
    int mismatches, checked;

    axsf_fifo #(.DEPTH(DEPTH)) dut (
        .pclk(pclk), .presetn(presetn), .arestn(arestn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .s_axis_tvalid(s_valid), .s_axis_tready(s_ready), .s_axis_tdata(s_word[52:21]),
        .s_axis_tstrb(s_word[20:17]), .s_axis_tkeep(s_word[16:13]), .s_axis_tlast(s_word[12]),
        .s_axis_tdest(s_word[11:8]), .s_axis_tid(s_word[7:4]), .s_axis_tuser(s_word[3:0]),
        .m_axis_tvalid(m_valid), .m_axis_tready(m_ready), .m_axis_tdata(m_word[52:21]),
        .m_axis_tstrb(m_word[20:17]), .m_axis_tkeep(m_word[16:13]), .m_axis_tlast(m_word[12]),
        .m_axis_tdest(m_word[11:8]), .m_axis_tid(m_word[7:4]), .m_axis_tuser(m_word[3:0]),
        .data_count(data_count)
    );

    axsf_sink_model sink (
        .pclk(pclk), .presetn(presetn), .m_axis_tvalid(m_valid), .m_word(m_word),
        .m_axis_tready(m_ready), .mode(mode), .got(got), .got_word(got_word)
    );

    task automatic check(input string name, input logic [52:0] seen, input logic [52:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // Every sideband field is drawn from the word index: strb and dest from the same low bits, id and user from the high bits
    function automatic logic [52:0] mk(input logic [7:0] i);
        return {24'hA5C300, i, i[3:0], ~i[3:0], i[0], i[3:0], ~i[7:4], i[7:4] ^ 4'h9};
    endfunction : mk

    // Offer one word and hold it until taken; ready is judged at the very edge that moves the word
    task automatic push(input logic [52:0] w);
        logic ok;
        int n;
        s_valid <= 1'b1;
        s_word <= w;
        n = 0;
        do
        begin
            @(posedge pclk);
            ok = (s_ready === 1'b1);
            n++;
        end
        while (!ok && n < 200);
        exp_q.push_back(w);
        check("write taken", 53'(ok), 53'h1);
    endtask : push

    // One APB transfer; an idle cycle follows so the strobes are never set twice at one edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        logic ok;
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
            n++;
        end
        while (!ok && n < 50);
        check("apb answer", 53'(ok), 53'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(negedge pclk);
        check("drained", {m_valid, data_count, 1'(exp_q.size() == 0)}, 7'h01);
        @(posedge pclk);
    endtask : drain

    // Each beat taken by the sink must be the oldest word still queued, sideband included
    always @(negedge pclk)
    begin
        if (got === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("surplus beat", 53'h1, 53'h0);
            else
                check("read word", got_word, exp_q.pop_front());
        end
    end

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Watchdog: the run needs well under a thousand cycles
    initial
    begin
        #(40 * 5000);
        mismatches++;
        report_and_stop;
    end

    initial
    begin
        presetn = 1'b0;
        arestn = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        s_valid = 1'b0;
        s_word = 53'h0;
        mode = 2'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        check("idle flags", {s_ready, m_valid, data_count}, 7'h40);
        @(posedge pclk);
        apb(1'b0, `AXSF_DEPTH_OFS, 32'h0);
        check("depth reg", rd, 53'(DEPTH));
        apb(1'b1, `AXSF_STAT_OFS, 32'hFFFF_FFFF);
        apb(1'b0, `AXSF_STAT_OFS, 32'h0);
        check("status empty", {err, rd}, 33'h0_4000_0000);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        check("unmapped write", err, 53'h1);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped read", {err, rd}, 33'h1_0000_0000);
        // Count lags an accepted write by exactly one edge
        push(mk(8'h00));
        s_valid <= 1'b0;
        @(negedge pclk);
        check("count lag", data_count, 5'h00);
        @(negedge pclk);
        check("count one", data_count, 5'h01);
        @(posedge pclk);
        // Fill against a stalled sink, then offer one word too many and hold it
        for (int i = 1; i < DEPTH; i++)
            push(mk(8'(i)));
        s_valid <= 1'b0;
        @(posedge pclk);
        apb(1'b0, `AXSF_STAT_OFS, 32'h0);
        check("status full", rd, 32'h8000_0010);
        s_valid <= 1'b1;
        s_word <= mk(8'h10);
        repeat (3)
        begin
            @(negedge pclk);
            check("full flags", {s_ready, m_valid, data_count}, 7'h30);
        end
        @(posedge pclk);
        mode <= 2'h2;
        push(mk(8'h10));
        s_valid <= 1'b0;
        drain();
        // Simultaneous pushes and pops every cycle
        mode <= 2'h1;
        for (int i = 32; i < 40; i++)
            push(mk(8'(i)));
        s_valid <= 1'b0;
        drain();
        // Register flush empties a partly filled queue
        mode <= 2'h0;
        for (int i = 64; i < 67; i++)
            push(mk(8'(i)));
        s_valid <= 1'b0;
        @(posedge pclk);
        apb(1'b1, `AXSF_CTRL_OFS, 32'h0000_0001);
        exp_q.delete();
        repeat (2) @(negedge pclk);
        check("after flush", {s_ready, m_valid, data_count}, 7'h40);
        @(posedge pclk);
        // Optional queue reset arestn empties the queue, which then works again
        push(mk(8'h80));
        push(mk(8'h81));
        s_valid <= 1'b0;
        arestn <= 1'b0;
        @(posedge pclk);
        arestn <= 1'b1;
        exp_q.delete();
        repeat (2) @(negedge pclk);
        check("after reset", {s_ready, m_valid, data_count}, 7'h40);
        @(posedge pclk);
        mode <= 2'h1;
        push(mk(8'h55));
        s_valid <= 1'b0;
        drain();
        report_and_stop;
    end
endmodule : axsf_fifo_tb
